/* shared/mrcf_map.svh */
`ifndef MRCF_MAP_SVH
`define MRCF_MAP_SVH
`define MRCF_OFS_CFG 8'h00
`define MRCF_OFS_PLO 8'h04
`define MRCF_OFS_PHI 8'h08
`define MRCF_OFS_STAT 8'h0C
`define MRCF_CFG_MASK 32'h7FFF_47BF
`define MRCF_CFG_RST 32'h0000_0000
`define MRCF_PA_RST 48'h0000_0000_0000
`define MRCF_B_RRST 0
`define MRCF_B_EN 1
`define MRCF_B_VLAN 2
`define MRCF_B_FCS 3
`define MRCF_B_JUMBO 4
`define MRCF_B_FC 5
`define MRCF_B_PRE 7
`define MRCF_B_LTDIS 8
`define MRCF_B_CTLDIS 9
`define MRCF_B_INH 10
`define MRCF_B_MTUON 14
`define MRCF_F_MTU 30:16
`define MRCF_MAX_STD 15'h05EE
`define MRCF_MAX_VLAN 15'h05F2
`define MRCF_MIN_LEN 15'h0040
`define MRCF_CNT_MAX 15'h7FFF
`define MRCF_HDR_STD 16'h0012
`define MRCF_HDR_VLAN 16'h0016
`define MRCF_LEN_MAX 16'h05DC
`define MRCF_MIN_PAY 16'h002E
`define MRCF_T_VLAN 16'h8100
`define MRCF_T_CTL 16'h8808
`define MRCF_OP_PAUSE 16'h0001
`define MRCF_CRC_INIT 32'hFFFF_FFFF
`define MRCF_CRC_POLY 32'hEDB8_8320
`define MRCF_CRC_RES 32'hDEBB_20E3
`define MRCF_XG_IDLE 8'h07
`define MRCF_XG_SEQ 8'h9C
`define MRCF_XG_RF 8'h02
`define MRCF_XG_ZERO 8'h00
`endif

/* shared/mrcf_pkg.sv */
`default_nettype none
package mrcf_pkg;
  typedef struct packed {
    logic pre;
    logic last;
    logic [7:0] data;
  } mrcf_beat_s;
  typedef struct packed {
    logic good;
    logic fcs_err;
    logic len_err;
    logic lt_err;
    logic vlan_err;
    logic pause;
  } mrcf_res_s;
  typedef struct packed {
    logic ctl;
    logic [7:0] data;
  } mrcf_xg_s;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_RUN = 3'h2,
    RX_SKIP = 3'h4
  } mrcf_rx_e;
endpackage
`default_nettype wire

/* design/mrcf_rx_cfg.sv */
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "mrcf_map.svh"

// Summary of operation
// - A flow control frame matches if its destination is the pause address.
// - The pause address only affects flow control matching, nothing else.
// - First address byte on the wire sits in the lowest byte of the field.
// - With the size limit on, the size field is the largest frame allowed.
// - With the size limit off, the size field is ignored.
// - Unless inhibited, local fault received sends remote fault out.
// - Unless inhibited or local fault is received, remote fault received makes the output send idles.
// - When inhibited, the output always forwards the transmitter's data.
// - With the check disabled, long control frames are not marked bad.
// - Length/type field check runs when its disable bit is clear.
// - Preamble kept when the preserve bit is set, else dropped.
// - Flow control on: good pause frames raise pause_hit; off: they are not flagged.
// - With the size limit off, jumbo off limits frames to the legal maximum; on means no limit.
// - In-band bit set passes the check sequence on; clear strips it.
// - The check sequence is verified on every frame.
// - Tagged frames are accepted when the tag enable bit is set.
// - The receiver takes a frame only if its enable bit is set at the frame's first beat.
// - The receiver reset bit holds the receiver in reset.
// - Status bit 1 shows remote fault being received.
// - Status bit 0 shows local fault being received.
module mrcf_rx_cfg #(
  parameter int ADDR_BITS = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_in_valid,
  input wire mrcf_pkg::mrcf_beat_s rx_in,
  output logic rx_out_valid,
  output mrcf_pkg::mrcf_beat_s rx_out,
  output logic res_valid,
  output mrcf_pkg::mrcf_res_s res,
  output logic pause_hit,
  input wire logic fault_local_pin,
  input wire logic fault_remote_pin,
  input wire mrcf_pkg::mrcf_xg_s mac_tx,
  output mrcf_pkg::mrcf_xg_s rs_tx
);

  if (ADDR_BITS < 4 || ADDR_BITS > 32) begin : g_chk
    $error("ADDR_BITS must lie between 4 and 32");
  end

  function automatic logic [31:0] crc8(input logic [31:0] c,
                                       input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MRCF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic [31:0] cfg_q, cfg_d;
  logic [47:0] pa_q, pa_d;
  logic [ADDR_BITS-1:0] ad_q, ad_d;
  logic wr_q, wr_d, rd_q, rd_d, rdok_q, rdok_d;
  logic [31:0] hrdata_q, hrdata_d;

  mrcf_pkg::mrcf_rx_e st_q, st_d;
  logic inb_q, inb_d, kpre_q, kpre_d;
  logic [14:0] cnt_q, cnt_d;
  logic [31:0] crc_q, crc_d;
  logic [47:0] da_q, da_d;
  logic [15:0] ty_q, ty_d, op_q, op_d, it_q, it_d;
  logic [3:0][7:0] pipe_q, pipe_d;
  logic [2:0] fill_q, fill_d;
  logic out_v_q, out_v_d, res_v_q, res_v_d, ph_q, ph_d;
  mrcf_pkg::mrcf_beat_s out_q, out_d;
  mrcf_pkg::mrcf_res_s res_q, res_d;

  logic [2:0] lf_s_q, lf_s_d, rf_s_q, rf_s_d;
  logic lf_q, lf_d, rf_q, rf_d;
  logic [1:0] lane_q, lane_d;
  mrcf_pkg::mrcf_xg_s rs_q, rs_d;

  // Reads take one wait state so that a write just ahead is always seen.
  assign hreadyout = !(rd_q && !rdok_q);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_comb begin
    cfg_d = cfg_q;
    pa_d = pa_q;
    ad_d = ad_q;
    wr_d = 1'b0;
    rd_d = rd_q;
    rdok_d = 1'b0;
    hrdata_d = hrdata_q;
    if (wr_q) begin
      case (ad_q)
        ADDR_BITS'(`MRCF_OFS_CFG): cfg_d = hwdata & `MRCF_CFG_MASK;
        ADDR_BITS'(`MRCF_OFS_PLO): pa_d[31:0] = hwdata;
        ADDR_BITS'(`MRCF_OFS_PHI): pa_d[47:32] = hwdata[15:0];
        default: ;
      endcase
    end
    if (rd_q && !rdok_q) begin
      rdok_d = 1'b1;
      case (ad_q)
        ADDR_BITS'(`MRCF_OFS_CFG): hrdata_d = cfg_q;
        ADDR_BITS'(`MRCF_OFS_PLO): hrdata_d = pa_q[31:0];
        ADDR_BITS'(`MRCF_OFS_PHI): hrdata_d = {16'h0000, pa_q[47:32]};
        ADDR_BITS'(`MRCF_OFS_STAT):
          hrdata_d = {24'h00_0000, res_q, rf_q, lf_q};
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
    if (rdok_q) begin
      rd_d = 1'b0;
    end
    if (hsel && htrans[1] && hready) begin
      ad_d = haddr[ADDR_BITS-1:0];
      wr_d = hwrite;
      rd_d = !hwrite;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `MRCF_CFG_RST;
      pa_q <= `MRCF_PA_RST;
      ad_q <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdok_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      pa_q <= pa_d;
      ad_q <= ad_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      rdok_q <= rdok_d;
      hrdata_q <= hrdata_d;
    end
  end

  // The in-band and preamble bits are caught at the first beat so a frame never changes form.
  always_comb begin
    logic run, inb, kp, tg, ctl, over;
    logic [14:0] c, c2, mx;
    logic [31:0] k, k2;
    logic [2:0] f;
    logic [15:0] lt, pay;
    mrcf_pkg::mrcf_res_s r;
    run = 1'b0;
    inb = inb_q;
    kp = kpre_q;
    tg = 1'b0;
    ctl = 1'b0;
    over = 1'b0;
    c = cnt_q;
    c2 = cnt_q;
    mx = `MRCF_MAX_STD;
    k = crc_q;
    k2 = crc_q;
    f = fill_q;
    lt = 16'h0000;
    pay = 16'h0000;
    r = res_q;
    st_d = st_q;
    inb_d = inb_q;
    kpre_d = kpre_q;
    cnt_d = cnt_q;
    crc_d = crc_q;
    da_d = da_q;
    ty_d = ty_q;
    op_d = op_q;
    it_d = it_q;
    pipe_d = pipe_q;
    fill_d = fill_q;
    out_v_d = 1'b0;
    out_d = out_q;
    res_v_d = 1'b0;
    res_d = res_q;
    ph_d = 1'b0;
    if (cfg_q[`MRCF_B_RRST]) begin
      st_d = mrcf_pkg::RX_IDLE;
      cnt_d = 15'h0000;
      crc_d = `MRCF_CRC_INIT;
      fill_d = 3'h0;
    end else if (rx_in_valid) begin
      if (st_q == mrcf_pkg::RX_IDLE) begin
        inb = cfg_q[`MRCF_B_FCS];
        kp = cfg_q[`MRCF_B_PRE];
        c = 15'h0000;
        k = `MRCF_CRC_INIT;
        f = 3'h0;
        inb_d = inb;
        kpre_d = kp;
        // A leading preamble beat must not carry the last frame's count on.
        cnt_d = c;
        crc_d = k;
        fill_d = f;
        run = cfg_q[`MRCF_B_EN];
        st_d = run ? mrcf_pkg::RX_RUN : mrcf_pkg::RX_SKIP;
      end else begin
        run = (st_q == mrcf_pkg::RX_RUN);
      end
      if (run && rx_in.pre) begin
        out_v_d = kp;
        out_d = rx_in;
      end else if (run) begin
        k2 = crc8(k, rx_in.data);
        c2 = (c == `MRCF_CNT_MAX) ? c : c + 15'h0001;
        if (c < 15'h0006) begin
          da_d[{c[2:0], 3'h0} +: 8] = rx_in.data;
        end
        case (c)
          15'h000C: ty_d[15:8] = rx_in.data;
          15'h000D: ty_d[7:0] = rx_in.data;
          15'h000E: op_d[15:8] = rx_in.data;
          15'h000F: op_d[7:0] = rx_in.data;
          15'h0010: it_d[15:8] = rx_in.data;
          15'h0011: it_d[7:0] = rx_in.data;
          default: ;
        endcase
        if (inb) begin
          out_v_d = 1'b1;
          out_d = rx_in;
        end else begin
          // Four bytes are held back so the sequence can be dropped.
          out_v_d = (f == 3'h4);
          out_d = '{pre: 1'b0, last: rx_in.last, data: pipe_q[3]};
          pipe_d = {pipe_q[2:0], rx_in.data};
          fill_d = (f == 3'h4) ? f : f + 3'h1;
        end
        cnt_d = c2;
        crc_d = k2;
        if (rx_in.last) begin
          tg = (ty_d == `MRCF_T_VLAN);
          ctl = (ty_d == `MRCF_T_CTL);
          lt = tg ? it_d : ty_d;
          pay = {1'b0, c2} - (tg ? `MRCF_HDR_VLAN : `MRCF_HDR_STD);
          mx = (tg && cfg_q[`MRCF_B_VLAN]) ? `MRCF_MAX_VLAN : `MRCF_MAX_STD;
          if (cfg_q[`MRCF_B_MTUON]) begin
            over = c2 > cfg_q[`MRCF_F_MTU];
          end else begin
            over = !cfg_q[`MRCF_B_JUMBO] && c2 > mx;
          end
          r.len_err = over || c2 < `MRCF_MIN_LEN ||
                      (ctl && !cfg_q[`MRCF_B_CTLDIS] && c2 > `MRCF_MIN_LEN);
          r.lt_err = !cfg_q[`MRCF_B_LTDIS] && lt <= `MRCF_LEN_MAX &&
                     !(lt == pay || (lt < `MRCF_MIN_PAY &&
                       pay == `MRCF_MIN_PAY));
          r.vlan_err = tg && !cfg_q[`MRCF_B_VLAN];
          r.fcs_err = (k2 != `MRCF_CRC_RES);
          // Only flow control frames ever look at the pause address.
          r.pause = cfg_q[`MRCF_B_FC] && ctl && op_d == `MRCF_OP_PAUSE &&
                    da_d == pa_q;
          r.good = !(r.len_err || r.lt_err || r.vlan_err || r.fcs_err);
          res_d = r;
          res_v_d = 1'b1;
          ph_d = r.pause && r.good;
        end
      end
      if (rx_in.last) begin
        st_d = mrcf_pkg::RX_IDLE;
        fill_d = 3'h0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= mrcf_pkg::RX_IDLE;
      inb_q <= 1'b0;
      kpre_q <= 1'b0;
      cnt_q <= 15'h0000;
      crc_q <= `MRCF_CRC_INIT;
      da_q <= 48'h0000_0000_0000;
      ty_q <= 16'h0000;
      op_q <= 16'h0000;
      it_q <= 16'h0000;
      pipe_q <= '0;
      fill_q <= 3'h0;
      out_v_q <= 1'b0;
      out_q <= '0;
      res_v_q <= 1'b0;
      res_q <= '0;
      ph_q <= 1'b0;
    end else begin
      st_q <= st_d;
      inb_q <= inb_d;
      kpre_q <= kpre_d;
      cnt_q <= cnt_d;
      crc_q <= crc_d;
      da_q <= da_d;
      ty_q <= ty_d;
      op_q <= op_d;
      it_q <= it_d;
      pipe_q <= pipe_d;
      fill_q <= fill_d;
      out_v_q <= out_v_d;
      out_q <= out_d;
      res_v_q <= res_v_d;
      res_q <= res_d;
      ph_q <= ph_d;
    end
  end

  assign rx_out_valid = out_v_q;
  assign rx_out = out_q;
  assign res_valid = res_v_q;
  assign res = res_q;
  assign pause_hit = ph_q;
  assign rs_tx = rs_q;

  // A fault level is taken only once the last two stages agree.
  always_comb begin
    lf_s_d = {lf_s_q[1:0], fault_local_pin};
    rf_s_d = {rf_s_q[1:0], fault_remote_pin};
    lf_d = (lf_s_q[1] == lf_s_q[2]) ? lf_s_q[2] : lf_q;
    rf_d = (rf_s_q[1] == rf_s_q[2]) ? rf_s_q[2] : rf_q;
    lane_d = lane_q + 2'h1;
    rs_d = mac_tx;
    if (cfg_q[`MRCF_B_INH]) begin
      rs_d = mac_tx;
    end else if (lf_q) begin
      case (lane_q)
        2'h0: rs_d = '{ctl: 1'b1, data: `MRCF_XG_SEQ};
        2'h3: rs_d = '{ctl: 1'b0, data: `MRCF_XG_RF};
        default: rs_d = '{ctl: 1'b0, data: `MRCF_XG_ZERO};
      endcase
    end else if (rf_q) begin
      rs_d = '{ctl: 1'b1, data: `MRCF_XG_IDLE};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lf_s_q <= 3'h0;
      rf_s_q <= 3'h0;
      lf_q <= 1'b0;
      rf_q <= 1'b0;
      lane_q <= 2'h0;
      rs_q <= '0;
    end else begin
      lf_s_q <= lf_s_d;
      rf_s_q <= rf_s_d;
      lf_q <= lf_d;
      rf_q <= rf_d;
      lane_q <= lane_d;
      rs_q <= rs_d;
    end
  end

  property p_inhibit;
    @(posedge mclk) disable iff (!rst_n)
    cfg_q[`MRCF_B_INH] |=> rs_tx == $past(mac_tx);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("Inhibited output did not forward transmitter data.");

  property p_rf_send;
    @(posedge mclk) disable iff (!rst_n)
    (!cfg_q[`MRCF_B_INH] && lf_q && lane_q == 2'h0)
      |=> (rs_tx.ctl && rs_tx.data == `MRCF_XG_SEQ) ##3
          (rs_tx.data == `MRCF_XG_RF || !$past(lf_q) ||
           $past(cfg_q[`MRCF_B_INH]));
  endproperty
  a_rf_send: assert property (p_rf_send)
    else $error("Remote fault ordered set not sent on local fault.");

  property p_idle_send;
    @(posedge mclk) disable iff (!rst_n)
    (!cfg_q[`MRCF_B_INH] && !lf_q && rf_q)
      |=> rs_tx.ctl && rs_tx.data == `MRCF_XG_IDLE;
  endproperty
  a_idle_send: assert property (p_idle_send)
    else $error("Idle not sent while remote fault received.");

  property p_lf_stat;
    @(posedge mclk) disable iff (!rst_n)
    $rose(fault_local_pin) ##1 fault_local_pin [*3] |=> lf_q;
  endproperty
  a_lf_stat: assert property (p_lf_stat)
    else $error("Local fault status missed a steady fault.");

  property p_rf_stat;
    @(posedge mclk) disable iff (!rst_n)
    $fell(fault_remote_pin) ##1 !fault_remote_pin [*3] |=> !rf_q;
  endproperty
  a_rf_stat: assert property (p_rf_stat)
    else $error("Remote fault status did not clear.");

  property p_disabled;
    @(posedge mclk) disable iff (!rst_n)
    (st_q == mrcf_pkg::RX_SKIP) |=> !rx_out_valid && !res_valid;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("Disabled receiver produced output.");

  property p_soft_rst;
    @(posedge mclk) disable iff (!rst_n)
    cfg_q[`MRCF_B_RRST] |=> !rx_out_valid && !res_valid &&
                             st_q == mrcf_pkg::RX_IDLE;
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("Receiver active while held in reset.");

  property p_pre_drop;
    @(posedge mclk) disable iff (!rst_n)
    (rx_in_valid && rx_in.pre && st_q == mrcf_pkg::RX_RUN && !kpre_q &&
     !cfg_q[`MRCF_B_RRST]) |=> !rx_out_valid;
  endproperty
  a_pre_drop: assert property (p_pre_drop)
    else $error("Preamble passed while it should be dropped.");

  property p_fcs_bad;
    @(posedge mclk) disable iff (!rst_n)
    res_valid && res.fcs_err |-> !res.good && !pause_hit;
  endproperty
  a_fcs_bad: assert property (p_fcs_bad)
    else $error("Frame with bad check sequence reported good.");

  property p_pause_gate;
    @(posedge mclk) disable iff (!rst_n)
    pause_hit |-> $past(cfg_q[`MRCF_B_FC]) && res.pause;
  endproperty
  a_pause_gate: assert property (p_pause_gate)
    else $error("Pause taken with flow control off.");

  property p_reserved;
    @(posedge mclk) disable iff (!rst_n)
    wr_q ##1 1'b1 |-> (cfg_q & ~`MRCF_CFG_MASK) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved configuration bit stored.");

endmodule
`default_nettype wire

/* verif/mrcf_src.sv */
`timescale 1ns/1ps
`default_nettype none
module mrcf_src (
  input wire logic mclk,
  output logic rx_in_valid,
  output mrcf_pkg::mrcf_beat_s rx_in
);
  initial begin
    rx_in_valid = 1'b0;
    rx_in = '0;
  end
  // Sends the preamble beats, then the frame bytes in queue order.
  task automatic send(input logic [7:0] q[$], input int np);
    int n;
    n = np + q.size();
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rx_in_valid <= 1'b1;
      rx_in.pre <= (i < np);
      rx_in.last <= (i == n - 1);
      rx_in.data <= (i < np) ? 8'h55 : q[i - np];
    end
    @(posedge mclk);
    rx_in_valid <= 1'b0;
    // The idle lane shows the inverse of the last beat, so a receiver that
    // ignores the strobe sees wrong data instead of a lucky copy.
    rx_in <= ~rx_in;
  endtask
endmodule
`default_nettype wire

/* verif/test_mrcf_rx_cfg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mrcf_map.svh"
module test_mrcf_rx_cfg;
  logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, fl, fr, hit;
  logic rx_in_valid, rx_out_valid, res_valid, pause_hit;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [5:0] rsv;
  logic [7:0] lastb;
  logic [7:0] q[$];
  mrcf_pkg::mrcf_beat_s rx_in, rx_out;
  mrcf_pkg::mrcf_res_s res;
  mrcf_pkg::mrcf_xg_s mac_tx, rs_tx;
  int n_mismatch, check_count, nout, npre, got;

  mrcf_rx_cfg u_dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_in_valid(rx_in_valid),
    .rx_in(rx_in), .rx_out_valid(rx_out_valid), .rx_out(rx_out),
    .res_valid(res_valid), .res(res), .pause_hit(pause_hit),
    .fault_local_pin(fl), .fault_remote_pin(fr), .mac_tx(mac_tx),
    .rs_tx(rs_tx));
  mrcf_src u_src (.mclk(mclk), .rx_in_valid(rx_in_valid), .rx_in(rx_in));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (rx_out_valid && rx_out.pre)
      npre++;
    if (rx_out_valid && !rx_out.pre)
      nout++;
    if (rx_out_valid && rx_out.last)
      lastb = rx_out.data;
    if (res_valid) begin
      got++;
      rsv = res;
      hit = pause_hit;
    end
  end

  task automatic chk(input string s, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Each phase is held until hready is seen high at a rising edge.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge mclk);
    while (hreadyout !== 1'b1)
      @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
      @(posedge mclk);
    d = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    chk("register", rd, e);
  endtask

  function automatic logic [31:0] crc32(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    foreach (b[i]) begin
      c = c ^ {24'h0, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    return ~c;
  endfunction

  // mb is {destination matches pause address, corrupt check sequence}.
  task automatic run(input logic [31:0] cfg, input int n,
                     input logic [15:0] typ, input logic [1:0] mb,
                     input logic [5:0] e);
    logic [31:0] c;
    wr(`MRCF_OFS_CFG, cfg);
    q.delete();
    for (int i = 0; i < 6; i++)
      q.push_back(mb[1] ? 8'(8'hAA + 8'h11 * i) : 8'(i));
    for (int i = 0; i < 6; i++)
      q.push_back(8'h12);
    q.push_back(typ[15:8]);
    q.push_back(typ[7:0]);
    if (typ == 16'h8808) begin
      q.push_back(8'h00);
      q.push_back(8'h01);
    end
    while (q.size() < n - 4)
      q.push_back(8'(q.size()));
    c = crc32(q) ^ {31'h0, mb[0]};
    for (int i = 0; i < 4; i++)
      q.push_back(c[8*i +: 8]);
    nout = 0;
    npre = 0;
    got = 0;
    hit = 1'b0;
    lastb = 8'h00;
    u_src.send(q, 7);
    repeat (20) @(posedge mclk);
    chk("frames", 32'(got), 32'(e != 6'h0));
    if (e != 6'h0) begin
      chk("res", {26'h0, rsv}, {26'h0, e});
      chk("last_byte", 32'(lastb), 32'(cfg[3] ? q[n - 1] : q[n - 5]));
    end
    chk("pause_hit", {31'h0, hit}, {31'h0, e[5] & e[0]});
    chk("bytes", 32'(nout), e == 6'h0 ? 0 : cfg[3] ? n : n - 4);
    chk("preamble", 32'(npre), e != 6'h0 && cfg[7] ? 7 : 0);
  endtask

  task automatic stat(input logic [1:0] e);
    repeat (8) @(posedge mclk);
    ahb(1'b0, `MRCF_OFS_STAT, 32'h0, rd);
    chk("status", {30'h0, rd[1:0]}, {30'h0, e});
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    summarize;
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    fl = 1'b0;
    fr = 1'b0;
    mac_tx = 9'h000;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
      rdc(8'(4 * i), 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rdc(8'h10, 32'h0);
    wr(`MRCF_OFS_CFG, 32'hFFFF_FFFF);
    rdc(`MRCF_OFS_CFG, 32'h7FFF_47BF);
    wr(`MRCF_OFS_PLO, 32'hDDCC_BBAA);
    wr(`MRCF_OFS_PHI, 32'h0000_FFEE);
    rdc(`MRCF_OFS_PHI, 32'h0000_FFEE);
    run(32'h0000_000A, 64, 16'h0800, 2'h0, 6'h20);
    run(32'h0000_0002, 64, 16'h0800, 2'h0, 6'h20);
    run(32'h0000_008A, 64, 16'h0800, 2'h0, 6'h20);
    run(32'h0000_0082, 64, 16'h0800, 2'h0, 6'h20);
    run(32'h0000_000A, 64, 16'h0800, 2'h1, 6'h10);
    run(32'h0000_0022, 64, 16'h8808, 2'h2, 6'h21);
    run(32'h0000_0002, 64, 16'h8808, 2'h2, 6'h20);
    run(32'h0000_0022, 64, 16'h8808, 2'h0, 6'h20);
    run(32'h0000_0022, 64, 16'h8808, 2'h3, 6'h11);
    run(32'h0000_0022, 64, 16'h0800, 2'h2, 6'h20);
    run(32'h0000_0002, 1519, 16'h0800, 2'h0, 6'h08);
    run(32'h0000_0012, 1519, 16'h0800, 2'h0, 6'h20);
    run(32'h0064_4002, 101, 16'h0800, 2'h0, 6'h08);
    run(32'h0064_4002, 100, 16'h0800, 2'h0, 6'h20);
    run(32'h0064_0002, 101, 16'h0800, 2'h0, 6'h20);
    run(32'h0000_0002, 100, 16'h0020, 2'h0, 6'h04);
    run(32'h0000_0102, 100, 16'h0020, 2'h0, 6'h20);
    run(32'h0000_0002, 100, 16'h8808, 2'h0, 6'h08);
    run(32'h0000_0202, 100, 16'h8808, 2'h0, 6'h20);
    run(32'h0000_0006, 64, 16'h8100, 2'h0, 6'h20);
    run(32'h0000_0002, 64, 16'h8100, 2'h0, 6'h02);
    run(32'h0000_0000, 64, 16'h0800, 2'h0, 6'h00);
    run(32'h0000_0003, 64, 16'h0800, 2'h0, 6'h00);
    run(32'h8000_B842, 64, 16'h0800, 2'h0, 6'h20);
    rdc(`MRCF_OFS_CFG, 32'h0000_0002);
    mac_tx <= 9'h0A5;
    fl <= 1'b1;
    stat(2'h1);
    chk("last_res", {26'h0, rd[7:2]}, 32'h0000_0020);
    @(negedge mclk);
    for (int i = 0; i < 8 && rs_tx !== 9'h19C; i++)
      @(negedge mclk);
    chk("rf_lane0", {23'h0, rs_tx}, 32'h0000_019C);
    for (int i = 1; i < 4; i++) begin
      @(negedge mclk);
      chk("rf_lane", {23'h0, rs_tx}, i == 3 ? 32'h2 : 32'h0);
    end
    @(posedge mclk);
    fl <= 1'b0;
    fr <= 1'b1;
    stat(2'h2);
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      chk("idle", {23'h0, rs_tx}, 32'h0000_0107);
    end
    @(posedge mclk);
    fl <= 1'b1;
    wr(`MRCF_OFS_CFG, 32'h0000_0402);
    repeat (4) @(negedge mclk);
    chk("inhibit", {23'h0, rs_tx}, 32'h0000_00A5);
    @(posedge mclk);
    fl <= 1'b0;
    fr <= 1'b0;
    stat(2'h0);
    summarize;
  end
endmodule
`default_nettype wire
